// ---- logic/ssf_defs.vh ----
// constants for the serial status flag logic
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

// reset values of the status flags
`define SSF_TX_EMPTY_RST 1'h1
`define SSF_RX_FULL_RST 1'h0
`define SSF_OVERRUN_RST 1'h0
`define SSF_FRAMING_RST 1'h0

// reset values of the arming bits and the interrupt requests
`define SSF_ARM_RST 1'h0
`define SSF_INT_RST 1'h0

// level of a good stop bit
`define SSF_STOP_OK 1'h1

`endif

// ---- logic/ssf_flags.v ----
// status flag logic of an asynchronous serial channel
//
// Contract
// - receive-full clears on software write of 0 after reading it as 1
// - receive-full clears when a receive-triggered transfer reads the data
// - transmit-empty is held at 1 while transmit enable is 0
// - transmit-empty sets when a byte moves into the transmit shifter
// - writes only clear flags; writing 1 never sets a flag
`timescale 1ns/1ps
`include "ssf_defs.vh"

module ssf_flags (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // control
  input wire i_transmit_enable_bit,
  // software status access: read strobe and write of the flag bits
  input wire i_sts_rd,
  input wire i_sts_wr,
  input wire i_wr_tx_empty_flag,
  input wire i_wr_rx_full_flag,
  input wire i_wr_overrun_flag,
  input wire i_wr_framing_error_flag,
  // transfer controller service of the data registers
  input wire i_xfer_rx_data_rd,
  input wire i_xfer_tx_data_wr,
  // receiver and transmitter events
  input wire i_rx_done,
  input wire i_rx_stop_bit,
  input wire i_tx_load_shift,
  // flags and interrupt requests
  output reg o_tx_empty_flag,
  output reg o_rx_full_flag,
  output reg o_overrun_flag,
  output reg o_framing_error_flag,
  output reg o_rx_full_interrupt,
  output reg o_tx_empty_interrupt
);

  // --------------------------------------------------------------
  // read-as-one arming: a software clear needs a prior read of the flag at 1
  // --------------------------------------------------------------
  reg tx_arm_reg;
  reg rx_arm_reg;
  reg ovr_arm_reg;
  reg fer_arm_reg;

  wire tx_clr;
  wire rx_clr;
  wire ovr_clr;
  wire fer_clr;
  wire rx_good;
  wire rx_set;
  wire ovr_set;
  wire fer_set;
  wire tx_set;

  // of the written values only 0 clears (transfer accesses also clear tx/rx); a written 1 is ignored
  assign tx_clr = (i_sts_wr & tx_arm_reg & ~i_wr_tx_empty_flag) |
                  i_xfer_tx_data_wr;
  assign rx_clr = (i_sts_wr & rx_arm_reg & ~i_wr_rx_full_flag) |
                  i_xfer_rx_data_rd;
  assign ovr_clr = i_sts_wr & ovr_arm_reg & ~i_wr_overrun_flag;
  assign fer_clr = i_sts_wr & fer_arm_reg &
                   ~i_wr_framing_error_flag;

  assign fer_set = i_rx_done & (i_rx_stop_bit != `SSF_STOP_OK);
  assign ovr_set = i_rx_done & o_rx_full_flag;
  assign rx_good = i_rx_done & ~fer_set & ~o_rx_full_flag;
  assign rx_set = rx_good;
  assign tx_set = i_tx_load_shift | ~i_transmit_enable_bit;

  // --------------------------------------------------------------
  // next values of the flags, the arming bits and the requests
  // --------------------------------------------------------------
  reg tx_empty_next;
  reg rx_full_next;
  reg overrun_next;
  reg framing_next;
  reg tx_arm_next;
  reg rx_arm_next;
  reg ovr_arm_next;
  reg fer_arm_next;
  reg rx_int_next;
  reg tx_int_next;

  // --------------------------------------------------------------
  // transmit-empty flag: a set in the clearing cycle wins
  // --------------------------------------------------------------
  always @* begin
    tx_empty_next = o_tx_empty_flag;
    if (tx_clr) begin
      tx_empty_next = 1'h0;
    end
    // a disabled transmitter keeps the flag up even when cleared
    if (tx_set) begin
      tx_empty_next = 1'h1;
    end
  end

  // a read seeing 1 arms; any write or clear disarms
  always @* begin
    tx_arm_next = tx_arm_reg;
    if (i_sts_rd && o_tx_empty_flag) begin
      tx_arm_next = 1'h1;
    end else if (i_sts_wr || tx_clr) begin
      tx_arm_next = 1'h0;
    end
  end

  // --------------------------------------------------------------
  // receive-full flag: a set in the clearing cycle wins
  // --------------------------------------------------------------
  always @* begin
    rx_full_next = o_rx_full_flag;
    if (rx_clr) begin
      rx_full_next = 1'h0;
    end
    // framing error or overrun leave the flag as it stands
    if (rx_set) begin
      rx_full_next = 1'h1;
    end
  end

  // a read seeing 1 arms; any write or clear disarms
  always @* begin
    rx_arm_next = rx_arm_reg;
    if (i_sts_rd && o_rx_full_flag) begin
      rx_arm_next = 1'h1;
    end else if (i_sts_wr || rx_clr) begin
      rx_arm_next = 1'h0;
    end
  end

  // --------------------------------------------------------------
  // overrun flag: a set in the clearing cycle wins
  // --------------------------------------------------------------
  always @* begin
    overrun_next = o_overrun_flag;
    if (ovr_clr) begin
      overrun_next = 1'h0;
    end
    if (ovr_set) begin
      overrun_next = 1'h1;
    end
  end

  // only software clears this flag, so only a write disarms
  always @* begin
    ovr_arm_next = ovr_arm_reg;
    if (i_sts_rd && o_overrun_flag) begin
      ovr_arm_next = 1'h1;
    end else if (i_sts_wr) begin
      ovr_arm_next = 1'h0;
    end
  end

  // --------------------------------------------------------------
  // framing-error flag: a set in the clearing cycle wins
  // --------------------------------------------------------------
  always @* begin
    framing_next = o_framing_error_flag;
    if (fer_clr) begin
      framing_next = 1'h0;
    end
    if (fer_set) begin
      framing_next = 1'h1;
    end
  end

  // only software clears this flag, so only a write disarms
  always @* begin
    fer_arm_next = fer_arm_reg;
    if (i_sts_rd && o_framing_error_flag) begin
      fer_arm_next = 1'h1;
    end else if (i_sts_wr) begin
      fer_arm_next = 1'h0;
    end
  end

  // --------------------------------------------------------------
  // interrupt requests follow the next flag values, the transmit one only while transmit is enabled
  // --------------------------------------------------------------
  always @* begin
    rx_int_next = rx_full_next;
    // the transmit request is masked while transmit is disabled
    tx_int_next = 1'h0;
    if (i_transmit_enable_bit) begin
      tx_int_next = tx_empty_next;
    end
  end

  // --------------------------------------------------------------
  // flag, arming and request registers
  // --------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tx_empty_flag <= `SSF_TX_EMPTY_RST;
      o_rx_full_flag <= `SSF_RX_FULL_RST;
      o_overrun_flag <= `SSF_OVERRUN_RST;
      o_framing_error_flag <= `SSF_FRAMING_RST;
      tx_arm_reg <= `SSF_ARM_RST;
      rx_arm_reg <= `SSF_ARM_RST;
      ovr_arm_reg <= `SSF_ARM_RST;
      fer_arm_reg <= `SSF_ARM_RST;
      o_rx_full_interrupt <= `SSF_INT_RST;
      o_tx_empty_interrupt <= `SSF_INT_RST;
    end else begin
      o_tx_empty_flag <= tx_empty_next;
      o_rx_full_flag <= rx_full_next;
      o_overrun_flag <= overrun_next;
      o_framing_error_flag <= framing_next;
      tx_arm_reg <= tx_arm_next;
      rx_arm_reg <= rx_arm_next;
      ovr_arm_reg <= ovr_arm_next;
      fer_arm_reg <= fer_arm_next;
      o_rx_full_interrupt <= rx_int_next;
      o_tx_empty_interrupt <= tx_int_next;
    end
  end

endmodule

// ---- tb/ssf_monitor.sv ----
// assertions on the serial status flag ports
`timescale 1ns/1ps
module ssf_monitor(input wire i_mclk, i_rst_n, i_transmit_enable_bit,
  i_sts_rd, i_sts_wr, i_wr_rx_full_flag, i_xfer_rx_data_rd, i_rx_done,
  i_rx_stop_bit, i_tx_load_shift, o_tx_empty_flag, o_rx_full_flag,
  o_overrun_flag, o_framing_error_flag);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence armed_wr_s;
    i_sts_rd && o_rx_full_flag ##1 !i_sts_wr ##1
    i_sts_wr && !i_wr_rx_full_flag && !i_rx_done;
  endsequence
  rx_sw_clear_a: assert property (armed_wr_s |=> !o_rx_full_flag)
    else $error("rx full kept");
  rx_xfer_clear_a: assert property (i_xfer_rx_data_rd && !i_rx_done
    |=> !o_rx_full_flag) else $error("rx full kept");
  tx_off_a: assert property (!i_transmit_enable_bit
    |=> o_tx_empty_flag) else $error("tx empty low");
  tx_load_a: assert property (i_tx_load_shift |=> o_tx_empty_flag)
    else $error("tx empty low");
  no_set_a: assert property (!o_rx_full_flag && !i_rx_done
    |=> !o_rx_full_flag) else $error("rx full set");
  frame_err_a: assert property (i_rx_done && !i_rx_stop_bit
    |=> o_framing_error_flag && !$rose(o_rx_full_flag)) else $error("fe");
  overrun_a: assert property (i_rx_done && o_rx_full_flag
    |=> o_overrun_flag) else $error("overrun low");
endmodule
bind ssf_flags ssf_monitor i_mon(.*);

// ---- tb/ssf_peer.sv ----
// remote transmitter: one received frame per send request
`timescale 1ns/1ps
module ssf_peer(input wire i_mclk, i_send, i_bad,
  output reg o_rx_done = 1'h0, output reg o_rx_stop_bit = 1'h0);
  always @(posedge i_mclk) begin
    o_rx_done <= i_send;
    // stop level only valid with done, toggles otherwise
    o_rx_stop_bit <= i_send ? !i_bad : !o_rx_stop_bit;
  end
endmodule

// ---- tb/tb.sv ----
// self-checking testbench for the serial status flag logic
`timescale 1ns/1ps
module tb;
  reg i_mclk = 0, i_rst_n = 0, en = 0;
  reg [10:0] s = 11'h000;
  wire tx, rx, ov, fe, ri, ti, dn, sb;
  int mismatches = 0, checked = 0;
  always #4 i_mclk = ~i_mclk;
  ssf_peer i_peer(.i_mclk(i_mclk), .i_send(s[10]), .i_bad(s[9]),
    .o_rx_done(dn), .o_rx_stop_bit(sb));
  ssf_flags i_dut(.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_transmit_enable_bit(en), .i_sts_rd(s[8]), .i_sts_wr(s[7]),
    .i_wr_tx_empty_flag(s[6]), .i_wr_rx_full_flag(s[5]),
    .i_wr_overrun_flag(s[4]), .i_wr_framing_error_flag(s[3]),
    .i_xfer_rx_data_rd(s[2]), .i_xfer_tx_data_wr(s[1]), .i_rx_done(dn),
    .i_rx_stop_bit(sb), .i_tx_load_shift(s[0]), .o_tx_empty_flag(tx),
    .o_rx_full_flag(rx), .o_overrun_flag(ov), .o_framing_error_flag(fe),
    .o_rx_full_interrupt(ri), .o_tx_empty_interrupt(ti));
  task chk(input logic a, input logic e);
    checked++;
    if (a !== e) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, a, e);
    end
  endtask
  task go(input [10:0] v);
    @(posedge i_mclk) s <= v;
    @(posedge i_mclk) s <= 11'h000;
    if (v[10]) @(posedge i_mclk);
    #1;
  endtask
  task t_tx();
    @(posedge i_mclk) en <= 1'h1;
    go(11'h002);
    chk(tx, 1'h0);
    chk(ti, 1'h0);
    go(11'h001);
    chk(tx, 1'h1);
    chk(ti, 1'h1);
    @(posedge i_mclk) en <= 1'h0;
    go(11'h002);
    chk(tx, 1'h1);
    chk(ti, 1'h0);
  endtask
  task t_rx();
    go(11'h400);
    chk(ri, 1'h1);
    go(11'h080);
    chk(rx, 1'h1);
    go(11'h100);
    go(11'h080);
    chk(rx, 1'h0);
    go(11'h100);
    go(11'h0f8);
    chk(rx, 1'h0);
    go(11'h400);
    go(11'h400);
    chk(ov, 1'h1);
    go(11'h004);
    chk(rx, 1'h0);
    chk(ri, 1'h0);
    go(11'h600);
    chk(fe, 1'h1);
    chk(rx, 1'h0);
    go(11'h100);
    go(11'h098);
    chk(ov, 1'h1);
    chk(fe, 1'h1);
    go(11'h100);
    go(11'h080);
    chk(ov, 1'h0);
    chk(fe, 1'h0);
  endtask
  task end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000 mismatches++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    t_tx();
    t_rx();
    end_of_test();
  end
endmodule
